// [common/pio_pkg.sv]
// Constants for the parallel port block with peripheral pad sharing
// Contract
// R1: Enabled driving peripheral disables port driver
// R2: Idle enabled peripheral lets port drive pin
// R3: Three bits per pin: direction, latch, level
// R4: Direction one means input, driver off
// R5: Reset makes every implemented pin input
// R6: Latch reads latch, latch write updates latch
// R7: Level reads pins, level write updates latch
// R8: Unimplemented bits disabled and read zero
// R9: Input-only shared pins built without output mux
// R10: Output mux pair, peripheral wins over port
// R11: Analog-selected pins read low as level
// R12: Analog pin driven as output converts own level
// R13: Digital inputs never routed to converter
// R14: Master waits one cycle before port read
// R15: Port-owned pad: enable=~direction, data=latch
package pio_pkg;
  localparam int PORT_W = 16;
  localparam int ADR_W = 16;
  localparam int DAT_W = 32;
  // Register indices; byte address is four times the index
  localparam logic [ADR_W-1:0] DIR_IDX = 16'h02CC;
  localparam logic [ADR_W-1:0] LEVEL_IDX = 16'h02CE;
  localparam logic [ADR_W-1:0] LATCH_IDX = 16'h02D0;
  localparam logic [ADR_W-1:0] ANALOG_IDX = 16'h02A8;
  // Implemented bits of this port variant
  localparam logic [PORT_W-1:0] IMPL_MASK = 16'hE00A;
  // Bits whose pad is shared with a peripheral output
  localparam logic [PORT_W-1:0] SHARED_MASK = 16'hE000;
  localparam logic [PORT_W-1:0] DIR_RST = 16'hE00A;
  localparam logic [PORT_W-1:0] LATCH_RST = 16'h0000;
  localparam logic [PORT_W-1:0] ANALOG_RST = 16'h0000;
  localparam logic [DAT_W-1:0] UNMAPPED_DATA = 32'h0000_0000;
endpackage

// [rtl/parallel_io_port.sv]
// Parallel port: direction, latch and level registers with pad mux
`timescale 1ns/10ps
module parallel_io_port (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [pio_pkg::ADR_W-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [pio_pkg::DAT_W-1:0] wb_dat_i,
  output logic [pio_pkg::DAT_W-1:0] wb_dat_o,
  output logic wb_ack_o,
  // Pads
  input wire logic [pio_pkg::PORT_W-1:0] pad_in,
  output logic [pio_pkg::PORT_W-1:0] pad_out,
  output logic [pio_pkg::PORT_W-1:0] pad_oe_n,
  // Peripheral output requests
  input wire logic [pio_pkg::PORT_W-1:0] periph_en,
  input wire logic [pio_pkg::PORT_W-1:0] periph_drive,
  input wire logic [pio_pkg::PORT_W-1:0] periph_out,
  // Converter side
  output logic [pio_pkg::PORT_W-1:0] adc_route,
  output logic [pio_pkg::PORT_W-1:0] adc_level
);

  logic [pio_pkg::PORT_W-1:0] dir_q;
  logic [pio_pkg::PORT_W-1:0] dir_d;
  logic [pio_pkg::PORT_W-1:0] latch_q;
  logic [pio_pkg::PORT_W-1:0] latch_d;
  logic [pio_pkg::PORT_W-1:0] level_q;
  logic [pio_pkg::PORT_W-1:0] level_d;
  logic [pio_pkg::PORT_W-1:0] analog_q;
  logic [pio_pkg::PORT_W-1:0] analog_d;
  logic [pio_pkg::DAT_W-1:0] rdata_q;
  logic [pio_pkg::DAT_W-1:0] rdata_d;
  logic ack_q;

  // Checks share one clock and are muted during reset
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  // Bus decode
  wire req_w = wb_cyc_i & wb_stb_i;
  wire fire_w = req_w & ack_q;
  wire wr_fire_w = fire_w & wb_we_i;
  wire hit_dir_w = (wb_adr_i == {pio_pkg::DIR_IDX[pio_pkg::ADR_W-3:0], 2'b00});
  wire hit_level_w = (wb_adr_i == {pio_pkg::LEVEL_IDX[pio_pkg::ADR_W-3:0], 2'b00});
  wire hit_latch_w = (wb_adr_i == {pio_pkg::LATCH_IDX[pio_pkg::ADR_W-3:0], 2'b00});
  wire hit_analog_w = (wb_adr_i == {pio_pkg::ANALOG_IDX[pio_pkg::ADR_W-3:0], 2'b00});
  wire hit_none_w = !(hit_dir_w || hit_level_w || hit_latch_w || hit_analog_w);
  wire [pio_pkg::PORT_W-1:0] lane_mask_w = {{8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
  wire [pio_pkg::PORT_W-1:0] wdata_w = wb_dat_i[pio_pkg::PORT_W-1:0];

  // Byte-lane merge; unimplemented bits are forced to zero
  function automatic logic [pio_pkg::PORT_W-1:0] merge(
    input logic [pio_pkg::PORT_W-1:0] old_v,
    input logic [pio_pkg::PORT_W-1:0] new_v,
    input logic [pio_pkg::PORT_W-1:0] mask
  );
    merge = ((old_v & ~mask) | (new_v & mask)) & pio_pkg::IMPL_MASK;
  endfunction

  assign dir_d = (wr_fire_w && hit_dir_w) ? merge(dir_q, wdata_w, lane_mask_w) : dir_q; // R3
  // Writes to the level view land in the latch
  assign latch_d = (wr_fire_w && (hit_latch_w || hit_level_w)) ?
                   merge(latch_q, wdata_w, lane_mask_w) : latch_q; // R6 R7
  assign analog_d = (wr_fire_w && hit_analog_w) ?
                    merge(analog_q, wdata_w, lane_mask_w) : analog_q;
  // Analog pins read low; unimplemented pins read zero
  assign level_d = pad_in & pio_pkg::IMPL_MASK & ~analog_q; // R11 R8

  // Read data sampled in the request cycle, shown with ack
  logic [pio_pkg::PORT_W-1:0] rsel_w;
  assign rsel_w = hit_dir_w ? dir_q :
                  hit_level_w ? level_q : // R7
                  hit_latch_w ? latch_q : // R6
                  hit_analog_w ? analog_q : '0;
  assign rdata_d = (req_w && !ack_q) ?
                   {{(pio_pkg::DAT_W-pio_pkg::PORT_W){1'b0}}, rsel_w} : rdata_q;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      dir_q <= pio_pkg::DIR_RST; // R5
    end else begin
      dir_q <= dir_d;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      latch_q <= pio_pkg::LATCH_RST;
    end else begin
      latch_q <= latch_d;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      level_q <= '0;
    end else begin
      level_q <= level_d;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      analog_q <= pio_pkg::ANALOG_RST;
    end else begin
      analog_q <= analog_d;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata_q <= pio_pkg::UNMAPPED_DATA;
    end else begin
      rdata_q <= rdata_d;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= req_w & ~ack_q;
    end
  end

  assign wb_ack_o = ack_q;
  assign wb_dat_o = rdata_q;

  // Pad output path, one slice per pin
  logic [pio_pkg::PORT_W-1:0] own_w;
  genvar i;
  generate
    for (i = 0; i < pio_pkg::PORT_W; i++) begin : g_pin
      if (!pio_pkg::IMPL_MASK[i]) begin : g_absent
        // Disabled pin: driver off, nothing driven
        assign own_w[i] = 1'b0;
        assign pad_oe_n[i] = 1'b1; // R8
        assign pad_out[i] = 1'b0;
        chk_absent_pin_idle: assert property ( // R8
          pad_oe_n[i] && !pad_out[i] && !dir_q[i] && !latch_q[i]
          && !level_q[i] && !analog_q[i])
          else $error("absent pin not idle");
      end else if (pio_pkg::SHARED_MASK[i]) begin : g_shared
        // Peripheral only takes the pad while actively driving it
        assign own_w[i] = periph_en[i] & periph_drive[i]; // R1 R2
        assign pad_oe_n[i] = own_w[i] ? 1'b0 : dir_q[i]; // R10 R4 R15
        assign pad_out[i] = own_w[i] ? periph_out[i] : latch_q[i]; // R10 R15
        chk_shared_periph_wins: assert property ( // R10
          own_w[i]
          |-> !pad_oe_n[i] && (pad_out[i] == periph_out[i]))
          else $error("peripheral lost shared pad");
        chk_shared_port_path: assert property ( // R15
          !own_w[i]
          |-> (pad_oe_n[i] == dir_q[i]) && (pad_out[i] == latch_q[i]))
          else $error("port path wrong on shared pad");
      end else begin : g_dedicated
        // Input-only sharing needs no output mux
        assign own_w[i] = 1'b0;
        assign pad_oe_n[i] = dir_q[i]; // R9 R4 R15
        assign pad_out[i] = latch_q[i]; // R9 R15
        chk_dedicated_port_path: assert property ( // R9
          (pad_oe_n[i] == dir_q[i]) && (pad_out[i] == latch_q[i])
          && !own_w[i])
          else $error("dedicated pad not port driven");
      end
    end
  endgenerate

  // Converter sees analog-selected pins only; driven pins give their own level
  assign adc_route = analog_q & pio_pkg::IMPL_MASK; // R13
  assign adc_level = adc_route & ~pad_oe_n & pad_out; // R12

  // Checks

  logic wrote_dir_q;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wrote_dir_q <= 1'b0;
    end else if (wr_fire_w && hit_dir_w) begin
      wrote_dir_q <= 1'b1;
    end
  end

  chk_periph_owns_pad: assert property ( // R1
    ((own_w & pad_oe_n) == '0) && (((pad_out ^ periph_out) & own_w) == '0))
    else $error("peripheral did not own its pad");

  chk_port_owns_pad: assert property ( // R2
    ((((pad_oe_n ^ dir_q) | (pad_out ^ latch_q)) & ~own_w & pio_pkg::IMPL_MASK) == '0))
    else $error("port output path wrong while port owns pad");

  chk_input_no_drive: assert property ( // R4
    (((dir_q & ~own_w) & ~pad_oe_n) == '0))
    else $error("input pin driven");

  chk_dir_after_reset: assert property ( // R5
    !wrote_dir_q |-> dir_q == pio_pkg::DIR_RST)
    else $error("direction not all inputs after reset");

  chk_latch_write: assert property ( // R6
    (wr_fire_w && hit_latch_w && wb_sel_i[1:0] == 2'b11)
    |=> latch_q == ($past(wdata_w) & pio_pkg::IMPL_MASK))
    else $error("latch write lost");

  chk_level_write: assert property ( // R7
    (wr_fire_w && hit_level_w && wb_sel_i[1:0] == 2'b11)
    |=> (latch_q == ($past(wdata_w) & pio_pkg::IMPL_MASK)) ##1 !wb_ack_o)
    else $error("level write did not reach latch");

  chk_level_read: assert property ( // R7
    (req_w && !ack_q && !wb_we_i && hit_level_w)
    |=> wb_ack_o && wb_dat_o == {16'h0000, $past(level_q)})
    else $error("level read returned wrong data");

  chk_unimpl_zero: assert property ( // R8
    (((dir_q | latch_q | level_q | analog_q | ~pad_oe_n) & ~pio_pkg::IMPL_MASK) == '0))
    else $error("unimplemented bit not zero");

  chk_analog_low: assert property ( // R11
    ((level_q & $past(analog_q)) == '0))
    else $error("analog pin read high");

  chk_adc_path: assert property ( // R13
    ((adc_route & ~analog_q) == '0) && ((adc_level & ~adc_route) == '0))
    else $error("digital pin routed to converter");

  chk_dir_write: assert property ( // R3
    (wr_fire_w && hit_dir_w && wb_sel_i[1:0] == 2'b11)
    |=> dir_q == ($past(wdata_w) & pio_pkg::IMPL_MASK))
    else $error("direction write lost");

  chk_analog_write: assert property ( // R11
    (wr_fire_w && hit_analog_w && wb_sel_i[1:0] == 2'b11)
    |=> analog_q == ($past(wdata_w) & pio_pkg::IMPL_MASK))
    else $error("analog config write lost");

  chk_dir_read: assert property ( // R3
    (req_w && !ack_q && !wb_we_i && hit_dir_w)
    |=> wb_dat_o == {16'h0000, $past(dir_q)})
    else $error("direction read returned wrong data");

  chk_latch_read: assert property ( // R6
    (req_w && !ack_q && !wb_we_i && hit_latch_w)
    |=> wb_dat_o == {16'h0000, $past(latch_q)})
    else $error("latch read returned wrong data");

  chk_analog_read: assert property ( // R11
    (req_w && !ack_q && !wb_we_i && hit_analog_w)
    |=> wb_dat_o == {16'h0000, $past(analog_q)})
    else $error("analog config read returned wrong data");

  chk_unmapped_read: assert property ( // R8
    (req_w && !ack_q && !wb_we_i && hit_none_w)
    |=> wb_dat_o == pio_pkg::UNMAPPED_DATA)
    else $error("unmapped read not zero");

  chk_unmapped_write: assert property ( // R8
    (wr_fire_w && hit_none_w)
    |=> $stable(dir_q) && $stable(latch_q) && $stable(analog_q))
    else $error("unmapped write changed a register");

  chk_level_not_dir: assert property ( // R7
    (wr_fire_w && hit_level_w)
    |=> $stable(dir_q) && $stable(analog_q))
    else $error("level write touched direction or analog config");

  chk_latch_not_dir: assert property ( // R6
    (wr_fire_w && hit_latch_w)
    |=> $stable(dir_q) && $stable(analog_q))
    else $error("latch write touched direction or analog config");

  chk_dir_not_latch: assert property ( // R3
    (wr_fire_w && hit_dir_w)
    |=> $stable(latch_q) && $stable(analog_q))
    else $error("direction write touched latch or analog config");

  chk_analog_not_latch: assert property ( // R11
    (wr_fire_w && hit_analog_w)
    |=> $stable(latch_q) && $stable(dir_q))
    else $error("analog config write touched latch or direction");

  chk_upper_zero: assert property ( // R3
    wb_dat_o[pio_pkg::DAT_W-1:pio_pkg::PORT_W] == 16'h0000)
    else $error("upper read data not zero");

  chk_level_sample: assert property ( // R7
    level_q == ($past(pad_in) & pio_pkg::IMPL_MASK & ~$past(analog_q)))
    else $error("level view not the sampled pins");

  chk_adc_own_level: assert property ( // R12
    ((adc_route & ~dir_q & ~own_w & (adc_level ^ latch_q)) == '0)
    && ((adc_route & dir_q & ~own_w & adc_level) == '0))
    else $error("converter level not the driven level");

  chk_dedicated_no_mux: assert property ( // R9
    ((own_w & ~pio_pkg::SHARED_MASK) == '0))
    else $error("peripheral took a dedicated pad");

  chk_ack_after_req: assert property ( // R3
    (req_w && !ack_q)
    |=> wb_ack_o)
    else $error("request not acknowledged");

  chk_ack_one_cycle: assert property ( // R3
    wb_ack_o
    |=> !wb_ack_o)
    else $error("ack longer than one cycle");

  chk_ack_needs_req: assert property ( // R3
    !req_w
    |=> !wb_ack_o)
    else $error("ack without request");

  chk_rdata_hold: assert property ( // R6
    !(req_w && !ack_q)
    |=> $stable(wb_dat_o))
    else $error("read data changed without request");

  chk_regs_need_write: assert property ( // R3
    !wr_fire_w
    |=> $stable(dir_q) && $stable(latch_q) && $stable(analog_q))
    else $error("register changed without acked write");

  // Main scenarios
  cov_periph_takes_pad: cover property (
    (own_w != '0) ##1 (own_w == '0));
  cov_level_write: cover property (wr_fire_w && hit_level_w);
  cov_read_back: cover property (
    (wr_fire_w && hit_latch_w) ##[2:10] (fire_w && !wb_we_i && hit_latch_w));
  cov_analog_driven: cover property (
    adc_level != '0);
  cov_unmapped_read: cover property (
    fire_w && !wb_we_i && hit_none_w);

endmodule

// [bench/pio_partner.sv]
// Pad wire model: resolves each pin from port driver and outside source
`timescale 1ns/10ps
module pio_partner (
  // Port side
  input wire logic [pio_pkg::PORT_W-1:0] pad_out,
  input wire logic [pio_pkg::PORT_W-1:0] pad_oe_n,
  // Outside world
  input wire logic [pio_pkg::PORT_W-1:0] ext_level,
  output logic [pio_pkg::PORT_W-1:0] pad_in
);
  // Active-low enable; an enabled port driver overrides the outside level
  assign pad_in = (pad_out & ~pad_oe_n) | (ext_level & pad_oe_n);
endmodule

// [bench/parallel_io_port_bench.sv]
// Self-checking bench for the parallel port with pad sharing
`timescale 1ns/10ps
module parallel_io_port_bench;
  localparam logic [15:0] IM = pio_pkg::IMPL_MASK;
  logic clk, rst_n, cyc, stb, we, ack;
  logic [3:0] sel;
  logic [15:0] adr, pin, pad_o, oe_n, en, drv, pout, ext, route, alev;
  logic [15:0] mdir, mlat, mana, own, eoe, eout, d;
  logic [31:0] wdat, rdat, q;
  logic [15:0] ra [4] = '{16'h0B30, 16'h0B40, 16'h0B38, 16'h0AA0};
  int fail_count, compares, k;
  parallel_io_port i_parallel_io_port (.clk(clk), .rst_n(rst_n), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
    .wb_dat_o(rdat), .wb_ack_o(ack), .pad_in(pin), .pad_out(pad_o), .pad_oe_n(oe_n),
    .periph_en(en), .periph_drive(drv), .periph_out(pout), .adc_route(route),
    .adc_level(alev));
  pio_partner i_pio_partner (.pad_out(pad_o), .pad_oe_n(oe_n), .ext_level(ext),
    .pad_in(pin));
  initial begin
    clk = 0;
    forever #2 clk = ~clk;
  end
  task automatic stop_test();
    $display("fail_count=%0d compares=%0d", fail_count, compares);
    if (fail_count == 0 && compares > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic chk(string nm, logic [31:0] e, logic [31:0] s);
    compares++;
    if (s !== e) begin
      $display("[ERR] %s exp %h got %h", nm, e, s);
      fail_count++;
    end
  endtask
  // Hold the request until ack is seen at a falling edge
  task automatic wb(bit w, logic [15:0] a, logic [31:0] dv, output logic [31:0] r);
    cyc <= 1; stb <= 1; we <= w; adr <= a; wdat <= dv;
    do @(negedge clk); while (ack !== 1'b1);
    @(posedge clk);
    r = rdat;
    cyc <= 0; stb <= 0;
    @(posedge clk);
  endtask
  task automatic check_all();
    own = pio_pkg::SHARED_MASK & en & drv;
    eoe = mdir & ~own;
    eout = (pout & own) | (mlat & ~own);
    chk("pad_oe_n", eoe & IM, oe_n & IM);
    chk("pad_out", eout & IM, pad_o & IM);
    chk("adc_route", mana & IM, route);
    chk("adc_level", mana & IM & ~eoe & eout, alev);
    wb(0, ra[0], 0, q);
    chk("dir", mdir, q);
    wb(0, ra[1], 0, q);
    chk("latch", mlat, q);
    wb(0, ra[2], 0, q);
    chk("level", ((eoe & ext) | (~eoe & eout)) & IM & ~mana, q);
    wb(0, 16'h0000, 0, q);
    chk("unmapped", 0, q);
    wb(1, 16'h0000, 32'hFFFF_FFFF, q);
  endtask
  initial begin
    repeat (5000) @(posedge clk);
    fail_count++;
    stop_test();
  end
  initial begin
    cyc = 0; stb = 0; we = 0; adr = 0; sel = 4'hF; wdat = 0; rst_n = 0;
    en = 0; drv = 0; pout = 0; ext = 0; fail_count = 0; compares = 0;
    mdir = pio_pkg::DIR_RST; mlat = 0; mana = 0;
    void'($urandom(88));
    repeat (4) @(posedge clk);
    rst_n <= 1;
    @(posedge clk);
    check_all();
    for (k = 0; k < 24; k++) begin
      en <= $urandom; drv <= $urandom; pout <= $urandom; ext <= $urandom;
      d = $urandom;
      wb(1, ra[k%4], {16'h0000, d}, q);
      case (k % 4)
        0: mdir = d & IM;
        1, 2: mlat = d & IM;
        default: mana = d;
      endcase
      repeat (2) @(posedge clk);
      check_all();
    end
    stop_test();
  end
endmodule
